// file: core/rtc_alarm_map.vh
// Purpose: register offsets, field positions, reset values and timing counts
//          for the calendar and alarm register block.
// Assumes: 32-bit AHB-Lite register bus, one aligned word per register.
// Notes:   included by bare name from the block's design file.
`ifndef RTC_ALARM_MAP_VH
`define RTC_ALARM_MAP_VH

// Register byte offsets (low address bits used by the decoder)
`define OFF_ALARM_CONTROL 5'h00
`define OFF_TIME_VALUE 5'h04
`define OFF_DATE_VALUE 5'h08
`define OFF_ALARM_TIME 5'h0C
`define OFF_ALARM_DATE 5'h10
`define OFF_CLOCK_CONTROL 5'h14

// Writable bits of each register; other bits read as zero except the alarm sync, value sync and half second status bits
`define MASK_ALARM_CONTROL_WR 32'h0000CFFF
`define MASK_TIME 32'h3F7F7F00
`define MASK_DATE 32'hFF1F3F07
`define MASK_ALARM_DATE 32'h001F3F07
`define MASK_CLOCK_CONTROL_WR 32'h00008008

// Field positions
`define BIT_ALARM_ENABLE 15
`define BIT_ENDLESS_REPEAT 14
`define BIT_ALARM_SYNC 12
`define BIT_CLOCK_ON 15
`define BIT_VALUE_WRITE_ENABLE 3
`define BIT_VALUE_SYNC 2
`define BIT_HALF_SECOND 1

// Alarm interval codes
`define IVL_HALF_SEC 4'h0
`define IVL_SECOND 4'h1
`define IVL_TEN_SEC 4'h2
`define IVL_MINUTE 4'h3
`define IVL_TEN_MIN 4'h4
`define IVL_HOUR 4'h5
`define IVL_DAY 4'h6
`define IVL_WEEK 4'h7
`define IVL_MONTH 4'h8
`define IVL_YEAR 4'h9

// Reset values: 00:00:00, year 00, month 01, day 01, weekday 0
`define RST_TIME 32'h00000000
`define RST_DATE 32'h00010100
`define RST_ALARM_DATE 32'h00010100

// Timing: RTC clock period in ps and the system clock period in ps
`define RTC_PERIOD_PS 30517578
`define CLK_PERIOD_PS 10000
// Clk cycles per RTC tick: the period ratio rounded down (3051)
`define RTC_DIV_CYCLES 12'hBEB
`define HALF_SEC_RTC_TICKS 15'h4000
`define SYNC_GUARD_TICKS 15'h0020

`endif

// file: core/rtc_alarm_regs.v
// Purpose: BCD calendar, alarm compare and repeat logic with an AHB-Lite
//          register slave.
// Assumes: rst_n is the power-on reset; the RTC clock is made from clk.
// Notes:   zero wait-state slave, response always OKAY.
// Contract
// - Four-bit interval code 0..9 selects half-second up to yearly alarm period.
// - Yearly alarm on February 29th fires only when that date really occurs.
// - Eight-bit repeat count: all ones gives 256 alarms, zero gives one.
// - Every alarm event decrements the repeat count by one.
// - Count wraps zero to all ones only with endless repeat; else stops.
// - Alarm control register is cleared only by power-on reset.
// - Time hours: tens in bits 31-28, units in bits 27-24.
// - Time minutes: tens in bits 23-20, units in bits 19-16.
// - Time seconds: tens in bits 15-12, units 11-8; low byte reads zero.
// - Unused top bits of hours, minutes, seconds tens digits read zero.
// - Time and date registers take writes only while write enable is set.
// - Date year: tens in bits 31-28, units in bits 27-24, fully writable.
// - Date month: tens in 23-20 with top three bits zero, units 19-16.
// - Date day: tens in 15-12 with top two bits zero, units 11-8.
// - Weekday in bits 3-0 range 0..6, bit 3 and bits 7-4 read zero.
// - Alarm time hours use the same layout as the time register.
// - Alarm time minutes: tens 23-20, units 19-16, top tens bit zero.
// - Alarm event when running value equals masked alarm value.
// - Hardware clears alarm enable on event with count zero, no endless repeat.
// - One RTC clock period passes between match and alarm event.
// - Alarm sync reads zero only when 32 or more RTC clocks from rollover.
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_alarm_map.vh"

module rtc_alarm_regs #(
	parameter [14:0] HALF_SEC_TICKS = `HALF_SEC_RTC_TICKS,
	parameter [11:0] RTC_DIV = `RTC_DIV_CYCLES
) (
	// Clock and power-on reset
	input wire clk,
	input wire rst_n,
	// AHB-Lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	// Alarm event, one clk cycle
	output reg alarm_event
);

	reg [31:0] alarm_control_reg;
	reg [31:0] time_reg;
	reg [31:0] date_reg;
	reg [31:0] alarm_time_reg;
	reg [31:0] alarm_date_reg;
	reg clock_on_reg;
	reg value_write_enable_reg;
	reg [11:0] rtc_div_reg;
	reg [14:0] presc_reg;
	reg [1:0] rst_sync_reg;
	reg [31:0] rd_mux;
	reg half_reg;
	reg eval_reg;
	reg eval_sec_reg;
	reg pending_reg;
	reg wr_pend_reg;
	reg [4:0] addr_reg;
	reg [31:0] time_next;
	reg [31:0] date_next;
	reg day_carry;
	reg leap;
	reg [7:0] dim;
	reg match;
	reg [31:0] cmp_time_mask;
	reg [31:0] cmp_date_mask;

	wire core_rst_n;
	wire rtc_en;
	wire rollover;
	wire sec_tick;
	wire alarm_sync;
	wire addr_phase;
	wire wr_ctrl;
	wire wr_time;
	wire wr_date;
	wire wr_atime;
	wire wr_adate;
	wire wr_clk;
	wire [3:0] interval_code;
	wire [7:0] repeat_count;
	wire fire;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addr_phase = hsel && htrans[1] && hready;

	// Reset asserts at once but releases two clocks late, clear of the clock edge
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_reg <= 2'b00;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign core_rst_n = rst_sync_reg[1];

	// Only the low five address bits are decoded; the slave is selected by hsel
	always @(posedge clk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			wr_pend_reg <= 1'b0;
			addr_reg <= 5'h00;
		end else begin
			wr_pend_reg <= addr_phase && hwrite;
			if (addr_phase) begin
				addr_reg <= haddr[4:0];
			end
		end
	end

	assign wr_ctrl = wr_pend_reg && (addr_reg == `OFF_ALARM_CONTROL);
	assign wr_time = wr_pend_reg && (addr_reg == `OFF_TIME_VALUE) && value_write_enable_reg;
	assign wr_date = wr_pend_reg && (addr_reg == `OFF_DATE_VALUE) && value_write_enable_reg;
	assign wr_atime = wr_pend_reg && (addr_reg == `OFF_ALARM_TIME);
	assign wr_adate = wr_pend_reg && (addr_reg == `OFF_ALARM_DATE);
	assign wr_clk = wr_pend_reg && (addr_reg == `OFF_CLOCK_CONTROL);

	// RTC clock enable derived from the system clock
	always @(posedge clk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			rtc_div_reg <= 12'h000;
		end else if (rtc_div_reg == RTC_DIV - 12'h001) begin
			rtc_div_reg <= 12'h000;
		end else begin
			rtc_div_reg <= rtc_div_reg + 12'h001;
		end
	end
	assign rtc_en = clock_on_reg && (rtc_div_reg == RTC_DIV - 12'h001);

	// Half-second prescaler; a time write restarts the second
	assign rollover = rtc_en && (presc_reg == HALF_SEC_TICKS - 15'h0001);
	assign sec_tick = rollover && half_reg;
	always @(posedge clk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			presc_reg <= 15'h0000;
			half_reg <= 1'b0;
		end else if (wr_time) begin
			presc_reg <= 15'h0000;
			half_reg <= 1'b0;
		end else if (rollover) begin
			presc_reg <= 15'h0000;
			half_reg <= ~half_reg;
		end else if (rtc_en) begin
			presc_reg <= presc_reg + 15'h0001;
		end
	end

	// Reads of repeat count may be torn while this is high
	assign alarm_sync = (presc_reg >= HALF_SEC_TICKS - `SYNC_GUARD_TICKS);

	// Leap year: BCD year divisible by four
	always @* begin
		leap = date_reg[28] ? (date_reg[27:24] == 4'h2 || date_reg[27:24] == 4'h6)
			: (date_reg[27:24] == 4'h0 || date_reg[27:24] == 4'h4 || date_reg[27:24] == 4'h8);
		case (date_reg[23:16])
			8'h02: dim = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: dim = 8'h30;
			default: dim = 8'h31;
		endcase
	end

	// Calendar advance, one second per tick, BCD digit by digit
	always @* begin
		time_next = time_reg;
		date_next = date_reg;
		day_carry = 1'b0;
		if (sec_tick) begin
			if (time_reg[11:8] != 4'h9) begin
				time_next[11:8] = time_reg[11:8] + 4'h1;
			end else begin
				time_next[11:8] = 4'h0;
				if (time_reg[15:12] != 4'h5) begin
					time_next[15:12] = time_reg[15:12] + 4'h1;
				end else begin
					time_next[15:12] = 4'h0;
					if (time_reg[19:16] != 4'h9) begin
						time_next[19:16] = time_reg[19:16] + 4'h1;
					end else begin
						time_next[19:16] = 4'h0;
						if (time_reg[23:20] != 4'h5) begin
							time_next[23:20] = time_reg[23:20] + 4'h1;
						end else begin
							time_next[23:20] = 4'h0;
							if (time_reg[31:24] == 8'h23) begin
								time_next[31:24] = 8'h00;
								day_carry = 1'b1;
							end else if (time_reg[27:24] == 4'h9) begin
								time_next[31:24] = {time_reg[31:28] + 4'h1, 4'h0};
							end else begin
								time_next[27:24] = time_reg[27:24] + 4'h1;
							end
						end
					end
				end
			end
		end
		if (day_carry) begin
			date_next[3:0] = (date_reg[3:0] == 4'h6) ? 4'h0 : date_reg[3:0] + 4'h1;
			if (date_reg[15:8] == dim) begin
				date_next[15:8] = 8'h01;
				if (date_reg[23:16] == 8'h12) begin
					date_next[23:16] = 8'h01;
					if (date_reg[27:24] != 4'h9) begin
						date_next[27:24] = date_reg[27:24] + 4'h1;
					end else begin
						date_next[27:24] = 4'h0;
						date_next[31:28] = (date_reg[31:28] == 4'h9) ? 4'h0
							: date_reg[31:28] + 4'h1;
					end
				end else if (date_reg[19:16] == 4'h9) begin
					date_next[23:16] = 8'h10;
				end else begin
					date_next[19:16] = date_reg[19:16] + 4'h1;
				end
			end else if (date_reg[11:8] == 4'h9) begin
				date_next[15:8] = {date_reg[15:12] + 4'h1, 4'h0};
			end else begin
				date_next[11:8] = date_reg[11:8] + 4'h1;
			end
		end
		if (wr_time) begin
			time_next = hwdata & `MASK_TIME;
		end
		if (wr_date) begin
			date_next = hwdata & `MASK_DATE;
		end
	end

	always @(posedge clk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			time_reg <= `RST_TIME;
			date_reg <= `RST_DATE;
		end else begin
			time_reg <= time_next;
			date_reg <= date_next;
		end
	end

	// Compare digit masks per interval; codes 1010 and up are reserved for software
	assign interval_code = alarm_control_reg[11:8];
	always @* begin
		cmp_time_mask = 32'h00000000;
		cmp_date_mask = 32'h00000000;
		case (interval_code)
			`IVL_TEN_SEC: cmp_time_mask = 32'h00000F00;
			`IVL_MINUTE: cmp_time_mask = 32'h0000FF00;
			`IVL_TEN_MIN: cmp_time_mask = 32'h000FFF00;
			`IVL_HOUR: cmp_time_mask = 32'h00FFFF00;
			`IVL_DAY: cmp_time_mask = 32'hFFFFFF00;
			`IVL_WEEK: begin
				cmp_time_mask = 32'hFFFFFF00;
				cmp_date_mask = 32'h0000000F;
			end
			`IVL_MONTH: begin
				cmp_time_mask = 32'hFFFFFF00;
				cmp_date_mask = 32'h0000FF00;
			end
			`IVL_YEAR: begin
				cmp_time_mask = 32'hFFFFFF00;
				cmp_date_mask = 32'h00FFFF00;
			end
			default: begin
				cmp_time_mask = 32'h00000000;
				cmp_date_mask = 32'h00000000;
			end
		endcase
		match = ((time_reg & cmp_time_mask) == (alarm_time_reg & cmp_time_mask)) &&
			((date_reg & cmp_date_mask) == (alarm_date_reg & cmp_date_mask));
	end

	// Evaluate the cycle after the count settles, fire one RTC clock later
	assign fire = pending_reg && rtc_en;
	always @(posedge clk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			eval_reg <= 1'b0;
			eval_sec_reg <= 1'b0;
			pending_reg <= 1'b0;
			alarm_event <= 1'b0;
		end else begin
			eval_reg <= rollover;
			eval_sec_reg <= sec_tick;
			alarm_event <= fire;
			if (fire || !alarm_control_reg[`BIT_ALARM_ENABLE]) begin
				pending_reg <= 1'b0;
			end else if (eval_reg && match &&
				(eval_sec_reg || interval_code == `IVL_HALF_SEC)) begin
				pending_reg <= 1'b1;
			end
		end
	end

	// Alarm control; rst_n is the power-on reset, nothing else clears it
	assign repeat_count = alarm_control_reg[7:0];
	always @(posedge clk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			alarm_control_reg <= 32'h00000000;
		end else if (wr_ctrl) begin
			// Software is expected to stay clear of the sync window here
			alarm_control_reg <= hwdata & `MASK_ALARM_CONTROL_WR;
		end else if (fire) begin
			if (repeat_count != 8'h00) begin
				alarm_control_reg[7:0] <= repeat_count - 8'h01;
			end else if (alarm_control_reg[`BIT_ENDLESS_REPEAT]) begin
				alarm_control_reg[7:0] <= 8'hFF;
			end else begin
				alarm_control_reg[`BIT_ALARM_ENABLE] <= 1'b0;
			end
		end
	end

	// Alarm compare values and clock control
	always @(posedge clk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			alarm_time_reg <= `RST_TIME;
			alarm_date_reg <= `RST_ALARM_DATE;
			clock_on_reg <= 1'b0;
			value_write_enable_reg <= 1'b0;
		end else begin
			if (wr_atime) begin
				alarm_time_reg <= hwdata & `MASK_TIME;
			end
			if (wr_adate) begin
				alarm_date_reg <= hwdata & `MASK_ALARM_DATE;
			end
			if (wr_clk) begin
				clock_on_reg <= hwdata[`BIT_CLOCK_ON];
				value_write_enable_reg <= hwdata[`BIT_VALUE_WRITE_ENABLE];
			end
		end
	end

	// Read data is picked at the address phase and held in a flip-flop; a write
	// still in its data phase is forwarded so a back-to-back read sees it
	always @* begin
		rd_mux = 32'h00000000;
		if (haddr[4:0] == `OFF_ALARM_CONTROL) begin
			rd_mux = wr_ctrl ? (hwdata & `MASK_ALARM_CONTROL_WR) : alarm_control_reg;
			rd_mux[`BIT_ALARM_SYNC] = alarm_sync;
		end else if (haddr[4:0] == `OFF_TIME_VALUE) begin
			rd_mux = time_next;
		end else if (haddr[4:0] == `OFF_DATE_VALUE) begin
			rd_mux = date_next;
		end else if (haddr[4:0] == `OFF_ALARM_TIME) begin
			rd_mux = wr_atime ? (hwdata & `MASK_TIME) : alarm_time_reg;
		end else if (haddr[4:0] == `OFF_ALARM_DATE) begin
			rd_mux = wr_adate ? (hwdata & `MASK_ALARM_DATE) : alarm_date_reg;
		end else if (haddr[4:0] == `OFF_CLOCK_CONTROL) begin
			rd_mux[`BIT_CLOCK_ON] = wr_clk ? hwdata[`BIT_CLOCK_ON] : clock_on_reg;
			rd_mux[`BIT_VALUE_WRITE_ENABLE] = wr_clk ? hwdata[`BIT_VALUE_WRITE_ENABLE]
				: value_write_enable_reg;
			rd_mux[`BIT_VALUE_SYNC] = alarm_sync;
			rd_mux[`BIT_HALF_SECOND] = half_reg;
		end
	end

	// Unmapped offsets read zero; the value stands until the next read is taken
	always @(posedge clk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			hrdata <= 32'h00000000;
		end else if (addr_phase && !hwrite) begin
			hrdata <= rd_mux;
		end
	end

endmodule // rtc_alarm_regs
`default_nettype wire

// file: test/rtc_alarm_chk.sv
// Purpose: port checks for the calendar and alarm register block.
// Assumes: zero wait-state slave; rst_n is the only reset.
// Notes: bound from the bench top.
`timescale 1ns/1ps
`default_nettype none
module rtc_alarm_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Alarm
	input wire logic alarm_event
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	logic rd;
	assign rd = hsel && htrans[1] && hready && !hwrite;
	a_ready_high: assert property (hreadyout) else $error("slave not ready");
	a_resp_okay: assert property (!hresp) else $error("error response");
	a_ctrl_zeros: assert property (rd && haddr[4:0] == 5'h00 |=>
		hrdata[31:16] == 16'h0000 && !hrdata[13]) else $error("ctrl spare bits set");
	a_time_zeros: assert property (rd && haddr[4:0] == 5'h04 |=>
		(hrdata & 32'hC08080FF) == 32'h0) else $error("time spare bits set");
	a_date_zeros: assert property (rd && haddr[4:0] == 5'h08 |=>
		(hrdata & 32'h00E0C0F8) == 32'h0) else $error("date spare bits set");
	a_alarm_zeros: assert property (rd && haddr[4:0] == 5'h0C |=>
		(hrdata & 32'hC08080FF) == 32'h0) else $error("alarm time spare bits set");
	a_unmapped_zero: assert property (rd && haddr[4:3] == 2'b11 |=>
		hrdata == 32'h0) else $error("unmapped read not zero");
	a_event_pulse: assert property (alarm_event |=> !alarm_event)
		else $error("alarm pulse too long");
	a_event_gap: assert property ($rose(alarm_event) |-> ##2 !alarm_event[*8])
		else $error("alarm events too close");
endmodule // rtc_alarm_chk
`default_nettype wire

// file: test/tb_rtc_alarm_regs.sv
// Purpose: register and alarm tests for the calendar block.
// Assumes: short prescaler parameters to keep the run brief.
// Notes: the bus is driven by plain tasks; hready loops back.
`timescale 1ns/1ps
`default_nettype none
module tb_rtc_alarm_regs;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'b00;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] r;
	wire [31:0] hrdata;
	wire hreadyout;
	wire hresp;
	wire alarm_event;
	int bad_count = 0;
	int compares = 0;
	int ev_cnt = 0;
	int base = 0;
	int cycles = 0;
	logic [31:0] exp_ev [3] = '{32'd20, 32'd10, 32'd1};
	rtc_alarm_regs #(.HALF_SEC_TICKS(15'h0028), .RTC_DIV(12'd4)) u_dut (.clk(clk),
		.rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .alarm_event(alarm_event));
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (alarm_event === 1'b1)
			ev_cnt++;
		if (cycles == 20000) begin
			bad_count++;
			wrap_up;
		end
	end
	task wrap_up;
		if (bad_count == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wait_ready;
		@(posedge clk);
		while (hreadyout !== 1'b1)
			@(posedge clk);
	endtask
	// Entered just after an edge; read data is taken at the data phase's closing edge
	task xfer(input logic [31:0] a, input logic w, input logic [31:0] wd);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		hsel <= 1'b1;
		wait_ready;
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= wd;
		wait_ready;
		r = hrdata;
	endtask
	task rd_chk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] exp);
		xfer(a, 1'b0, 32'h0);
		check(r & m, exp);
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		// The block releases its own reset two clocks after the pin
		repeat (2) @(posedge clk);
		rd_chk(32'h00, 32'hFFFFFFFF, 32'h0);
		rd_chk(32'h04, 32'hFFFFFFFF, 32'h0);
		rd_chk(32'h08, 32'hFFFFFFFF, 32'h00010100);
		xfer(32'h04, 1'b1, 32'hFFFFFFFF);
		rd_chk(32'h04, 32'hFFFFFFFF, 32'h0);
		xfer(32'h14, 1'b1, 32'h00000008);
		xfer(32'h04, 1'b1, 32'hFFFFFFFF);
		rd_chk(32'h04, 32'hFFFFFFFF, 32'h3F7F7F00);
		xfer(32'h08, 1'b1, 32'hFFFFFFFF);
		rd_chk(32'h08, 32'hFFFFFFFF, 32'hFF1F3F07);
		xfer(32'h0C, 1'b1, 32'hFFFFFFFF);
		rd_chk(32'h0C, 32'hFFFFFFFF, 32'h3F7F7F00);
		// Two legal interval codes that between them set every writable bit
		xfer(32'h00, 1'b1, 32'hFFFFF9FF);
		rd_chk(32'h00, 32'hFFFFEFFF, 32'h0000C9FF);
		xfer(32'h00, 1'b1, 32'hFFFFF6FF);
		rd_chk(32'h00, 32'hFFFFEFFF, 32'h0000C6FF);
		rd_chk(32'h18, 32'hFFFFFFFF, 32'h0);
		// Alarm at 00:00:00 so the ten-second code matches only on units zero
		xfer(32'h0C, 1'b1, 32'h0);
		xfer(32'h14, 1'b1, 32'h00008008);
		for (int i = 0; i < 3; i++) begin
			xfer(32'h04, 1'b1, 32'h0);
			xfer(32'h00, 1'b1, {20'h0000C, 4'(i), 8'h00});
			base = ev_cnt;
			repeat (3280) @(posedge clk);
			check(32'(ev_cnt - base), exp_ev[i]);
		end
		xfer(32'h04, 1'b1, 32'h0);
		xfer(32'h00, 1'b1, 32'h00008002);
		base = ev_cnt;
		repeat (1000) @(posedge clk);
		check(32'(ev_cnt - base), 32'd3);
		rd_chk(32'h00, 32'hFFFFEFFF, 32'h0);
		// Yearly alarm on February 29th: midnight rollover in a plain and a leap year
		xfer(32'h10, 1'b1, 32'h00022900);
		xfer(32'h08, 1'b1, 32'h01022800);
		xfer(32'h04, 1'b1, 32'h23595900);
		xfer(32'h00, 1'b1, 32'h00008900);
		base = ev_cnt;
		repeat (400) @(posedge clk);
		check(32'(ev_cnt - base), 32'd0);
		rd_chk(32'h08, 32'hFFFFFFFF, 32'h01030101);
		xfer(32'h08, 1'b1, 32'h04022800);
		xfer(32'h04, 1'b1, 32'h23595900);
		xfer(32'h00, 1'b1, 32'h00008900);
		base = ev_cnt;
		repeat (400) @(posedge clk);
		check(32'(ev_cnt - base), 32'd1);
		rd_chk(32'h08, 32'hFFFFFFFF, 32'h04022901);
		xfer(32'h04, 1'b1, 32'h0);
		xfer(32'h00, 1'b1, 32'h0000C000);
		base = ev_cnt;
		// Prescaler just restarted, then well inside the last 32 ticks
		rd_chk(32'h14, 32'h00000004, 32'h0);
		repeat (100) @(posedge clk);
		rd_chk(32'h00, 32'h00001000, 32'h00001000);
		while (ev_cnt == base)
			@(posedge clk);
		rd_chk(32'h00, 32'hFFFFEFFF, 32'h0000C0FF);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		rd_chk(32'h00, 32'hFFFFFFFF, 32'h0);
		wrap_up;
	end
endmodule // tb_rtc_alarm_regs
bind rtc_alarm_regs rtc_alarm_chk u_chk (.clk(clk), .rst_n(rst_n), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
	.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.alarm_event(alarm_event));
`default_nettype wire
